// [common/catm_defs.vh]
/*
  Constants for the charge accumulator and elapsed time block: register
  byte addresses (page * 8 + byte), field positions, reset values and the
  cycle counts of the one second tick and of the disconnect delay.
  Assumes a 125 MHz clock and a byte-wide register port.
*/
`ifndef CATM_DEFS_VH
`define CATM_DEFS_VH

`define CATM_SEC_CYC 27'h7735940
`define CATM_DISC_CYC 28'hee6b280

`define CATM_A_STATUS 6'h00
`define CATM_A_THRESH 6'h07
`define CATM_A_ICA 6'h0c
`define CATM_A_RSVD 6'h0f
`define CATM_A_CCA_LO 6'h3c
`define CATM_A_CCA_HI 6'h3d
`define CATM_A_DCA_LO 6'h3e
`define CATM_A_DCA_HI 6'h3f

`define CATM_G_ETM 4'h2
`define CATM_G_DISC 4'h4
`define CATM_G_EOC 4'h5

`define CATM_ST_ADC 0
`define CATM_ST_CA 1
`define CATM_ST_EE 2
`define CATM_TH_LO 6
`define CATM_TH_HI 7

`define CATM_ST_RST 3'h7
`define CATM_TH_RST 2'h0
`define CATM_DQ_IDLE 1'b1

`define CATM_THR_NONE 16'h0000
`define CATM_THR_2 16'h0002
`define CATM_THR_4 16'h0004
`define CATM_THR_8 16'h0008

`define CATM_LIFE_FRAC 23
`define CATM_NET_FRAC 18

`endif

// [core/catm_core.v]
/*
  Charge accounting and elapsed time meter: small-current dead band, net
  and lifetime charge counters with shadow requests, seconds counter with
  read snapshot, disconnect and charge_done_time_stamp time stamps.
  Assumes offset-corrected current samples arrive as one-cycle strobes in
  this clock domain, a byte register port driven by the bus engine, and a
  nonvolatile store that takes the shadow write requests.
*/
`timescale 1ns/10ps
`default_nettype none
`include "catm_defs.vh"

// How it works
// [RULE_01] Threshold top bits pick dead band 0/2/4/8.
// [RULE_02] Charge total grows only on charging samples.
// [RULE_03] Discharge total grows on discharging samples.
// [RULE_04] Enable or config low disables lifetime counters.
// [RULE_05] Host leaves page 07h alone when owned.
// [RULE_06] Shadow bit high copies counters to nonvolatile.
// [RULE_07] Enable low stops all; config low nets only.
// [RULE_08] Lifetime counters unsigned 16 bit, low first.
// [RULE_09] Net reaching zero leaves lifetime counters alone.
// [RULE_10] Recall eighth bit snapshots time for reads.
// [RULE_11] Thirty-two bit seconds counter from oscillator.
// [RULE_12] Two seconds low line stamps disconnect time.
// [RULE_13] After disconnect only the seconds counter runs.
// [RULE_14] Current reversal stamps charge_done_time_stamp time.
// [RULE_15] Time values are four bytes, low first.
// [RULE_16] Only samples above threshold are accumulated.
// [RULE_17] Each sample moves net and one lifetime total.
// [RULE_18] Status bits enable, config, shadow default one.
// [RULE_19] Fraction remainder kept between counter increments.
// [RULE_20] Counters wrap at full width without flag; the net counter holds at both ends instead.
module catm_core #(
  parameter [26:0] SEC_CYC = `CATM_SEC_CYC,
  parameter [27:0] DISC_CYC = `CATM_DISC_CYC
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire [5:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o,
  input wire recall_bit8_i,
  input wire sample_valid_i,
  input wire [15:0] sample_i,
  input wire dq_i,
  output wire sleep_o,
  output wire page7_owned_o,
  output wire shadow_wr_o,
  output wire [5:0] shadow_addr_o,
  output wire [15:0] shadow_data_o
);

  localparam NW = 8 + `CATM_NET_FRAC;
  localparam [2:0] ST_RST = `CATM_ST_RST;

  reg adc_en_ff;
  reg acc_cfg_ff;
  reg shadow_en_ff;
  reg [1:0] thr_sel_ff;
  reg [NW-1:0] net_ff;
  reg [31:0] etm_ff;
  reg [31:0] etm_hold_ff;
  reg [31:0] unplug_ff;
  reg [31:0] done_ff;
  reg [26:0] sec_cnt_ff;
  reg [27:0] low_cnt_ff;
  reg sleep_ff;
  reg last_pos_ff;
  reg [7:0] rdata_ff;
  reg shadow_wr_ff;
  reg [5:0] shadow_addr_ff;
  reg [15:0] shadow_data_ff;

  reg [NW-1:0] nxt_net;
  reg [NW:0] net_sum;
  reg [31:0] nxt_etm;
  reg [31:0] nxt_unplug;
  reg [31:0] nxt_done;
  reg [7:0] nxt_rdata;
  reg [15:0] thr_mag;
  reg [15:0] mag;

  wire dq_s;
  wire active;
  wire life_en;
  wire take;
  wire pos;
  wire neg;
  wire sec_tick;
  wire unplug_hit;
  wire wr_etm;
  wire wr_unplug;
  wire wr_done;
  wire [4:0] bsel;
  wire [15:0] cca;
  wire [15:0] dca;
  wire cca_bump;
  wire cca_wlo;
  wire cca_whi;
  wire dca_bump;
  wire dca_wlo;
  wire dca_whi;

  catm_sync2 u_dq_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .d_i(dq_i),
    .q_o(dq_s)
  );

  // Configuration byte and threshold byte.
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      adc_en_ff <= ST_RST[`CATM_ST_ADC]; // [RULE_18]
      acc_cfg_ff <= ST_RST[`CATM_ST_CA];
      shadow_en_ff <= ST_RST[`CATM_ST_EE];
      thr_sel_ff <= `CATM_TH_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `CATM_A_STATUS) begin
        adc_en_ff <= reg_wdata_i[`CATM_ST_ADC]; // [RULE_18]
        acc_cfg_ff <= reg_wdata_i[`CATM_ST_CA];
        shadow_en_ff <= reg_wdata_i[`CATM_ST_EE];
      end
      if (reg_addr_i == `CATM_A_THRESH) begin
        thr_sel_ff <= {reg_wdata_i[`CATM_TH_HI], reg_wdata_i[`CATM_TH_LO]};
      end
    end
  end

  // Mode decode: the converter enable gates the sample path, config the totals.
  assign active = adc_en_ff & ~sleep_ff; // [RULE_07] [RULE_13]
  assign life_en = active & acc_cfg_ff; // [RULE_04] [RULE_07]
  assign page7_owned_o = adc_en_ff & acc_cfg_ff; // [RULE_05]

  // Sample magnitude and dead band.
  always @* begin
    mag = sample_i[15] ? (~sample_i + 16'h0001) : sample_i;
    case (thr_sel_ff)
      2'b00: thr_mag = `CATM_THR_NONE; // [RULE_01]
      2'b01: thr_mag = `CATM_THR_2;
      2'b10: thr_mag = `CATM_THR_4;
      2'b11: thr_mag = `CATM_THR_8;
      default: thr_mag = `CATM_THR_NONE;
    endcase
  end

  assign take = sample_valid_i & active & (mag > thr_mag); // [RULE_16]
  assign pos = take & ~sample_i[15]; // [RULE_17]
  assign neg = take & sample_i[15];

  // Net counter with fraction; it holds at both ends instead of wrapping.
  always @* begin
    net_sum = {1'b0, net_ff} + {{(NW-15){1'b0}}, mag};
    nxt_net = net_ff;
    if (pos) begin
      nxt_net = net_sum[NW] ? {NW{1'b1}} : net_sum[NW-1:0]; // [RULE_17]
    end else if (neg) begin
      if (net_ff < {{(NW-16){1'b0}}, mag}) begin
        nxt_net = {NW{1'b0}};
      end else begin
        nxt_net = net_ff - {{(NW-16){1'b0}}, mag};
      end
    end
    if (reg_wr_i && reg_addr_i == `CATM_A_ICA) begin
      nxt_net[NW-1:NW-8] = reg_wdata_i;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      net_ff <= {NW{1'b0}};
    end else begin
      net_ff <= nxt_net;
    end
  end

  // Lifetime totals; an empty net counter never clears them.
  assign cca_wlo = reg_wr_i & life_en & (reg_addr_i == `CATM_A_CCA_LO);
  assign cca_whi = reg_wr_i & life_en & (reg_addr_i == `CATM_A_CCA_HI);
  assign dca_wlo = reg_wr_i & life_en & (reg_addr_i == `CATM_A_DCA_LO);
  assign dca_whi = reg_wr_i & life_en & (reg_addr_i == `CATM_A_DCA_HI);

  catm_life_acc u_charge_total (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .inc_i(pos & life_en), // [RULE_02] [RULE_09]
    .mag_i(mag),
    .wr_lo_i(cca_wlo),
    .wr_hi_i(cca_whi),
    .wdata_i(reg_wdata_i),
    .count_o(cca),
    .bumped_o(cca_bump)
  );

  catm_life_acc u_discharge_total (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .inc_i(neg & life_en), // [RULE_03] [RULE_09]
    .mag_i(mag),
    .wr_lo_i(dca_wlo),
    .wr_hi_i(dca_whi),
    .wdata_i(reg_wdata_i),
    .count_o(dca),
    .bumped_o(dca_bump)
  );

  // Shadow request goes out when an increment changed a whole count and the shadow bit is set.
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      shadow_wr_ff <= 1'b0;
      shadow_addr_ff <= 6'h00;
      shadow_data_ff <= 16'h0000;
    end else begin
      shadow_wr_ff <= life_en & shadow_en_ff & (cca_bump | dca_bump); // [RULE_06]
      if (cca_bump) begin
        shadow_addr_ff <= `CATM_A_CCA_LO;
        shadow_data_ff <= cca;
      end else if (dca_bump) begin
        shadow_addr_ff <= `CATM_A_DCA_LO;
        shadow_data_ff <= dca;
      end
    end
  end

  // One second tick from the clock.
  assign sec_tick = (sec_cnt_ff == SEC_CYC - 27'd1);

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      sec_cnt_ff <= 27'd0;
    end else if (sec_tick) begin
      sec_cnt_ff <= 27'd0;
    end else begin
      sec_cnt_ff <= sec_cnt_ff + 27'd1; // [RULE_11]
    end
  end

  // Disconnect detect from the synchronised data line.
  assign unplug_hit = ~dq_s & ~sleep_ff & (low_cnt_ff == DISC_CYC - 28'd1);

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      low_cnt_ff <= 28'd0;
      sleep_ff <= 1'b0;
    end else if (dq_s) begin
      low_cnt_ff <= 28'd0;
      sleep_ff <= 1'b0;
    end else if (unplug_hit) begin
      sleep_ff <= 1'b1; // [RULE_13]
    end else if (!sleep_ff) begin
      low_cnt_ff <= low_cnt_ff + 28'd1; // [RULE_12]
    end
  end

  assign sleep_o = sleep_ff;

  // Time registers; hardware stamps win over a same-cycle host write.
  assign bsel = {reg_addr_i[1:0], 3'b000};
  assign wr_etm = reg_wr_i & (reg_addr_i[5:2] == `CATM_G_ETM);
  assign wr_unplug = reg_wr_i & (reg_addr_i[5:2] == `CATM_G_DISC);
  assign wr_done = reg_wr_i & (reg_addr_i[5:2] == `CATM_G_EOC);

  always @* begin
    nxt_etm = etm_ff;
    if (wr_etm) begin
      nxt_etm[bsel +: 8] = reg_wdata_i;
    end else if (sec_tick) begin
      nxt_etm = etm_ff + 32'h0000_0001; // [RULE_11] [RULE_20]
    end
    nxt_unplug = unplug_ff;
    if (unplug_hit) begin
      nxt_unplug = etm_ff; // [RULE_12]
    end else if (wr_unplug) begin
      nxt_unplug[bsel +: 8] = reg_wdata_i;
    end
    nxt_done = done_ff;
    if (neg && last_pos_ff) begin
      nxt_done = etm_ff; // [RULE_14]
    end else if (wr_done) begin
      nxt_done[bsel +: 8] = reg_wdata_i;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      etm_ff <= 32'h0000_0000;
      etm_hold_ff <= 32'h0000_0000;
      unplug_ff <= 32'h0000_0000;
      done_ff <= 32'h0000_0000;
      last_pos_ff <= 1'b0;
    end else begin
      etm_ff <= nxt_etm;
      unplug_ff <= nxt_unplug;
      done_ff <= nxt_done;
      if (recall_bit8_i) begin
        etm_hold_ff <= etm_ff; // [RULE_10]
      end
      if (pos) begin
        last_pos_ff <= 1'b1;
      end else if (neg) begin
        last_pos_ff <= 1'b0;
      end
    end
  end

  // Read data, one cycle after the address.
  always @* begin
    case (reg_addr_i)
      `CATM_A_STATUS: nxt_rdata = {5'h00, shadow_en_ff, acc_cfg_ff, adc_en_ff};
      `CATM_A_THRESH: nxt_rdata = {thr_sel_ff, 6'h00}; // [RULE_01]
      `CATM_A_ICA: nxt_rdata = net_ff[NW-1:NW-8];
      `CATM_A_RSVD: nxt_rdata = 8'hff;
      `CATM_A_CCA_LO: nxt_rdata = page7_owned_o ? cca[7:0] : 8'h00; // [RULE_08]
      `CATM_A_CCA_HI: nxt_rdata = page7_owned_o ? cca[15:8] : 8'h00;
      `CATM_A_DCA_LO: nxt_rdata = page7_owned_o ? dca[7:0] : 8'h00;
      `CATM_A_DCA_HI: nxt_rdata = page7_owned_o ? dca[15:8] : 8'h00;
      default: begin
        case (reg_addr_i[5:2])
          `CATM_G_ETM: nxt_rdata = etm_hold_ff[bsel +: 8]; // [RULE_10] [RULE_15]
          `CATM_G_DISC: nxt_rdata = unplug_ff[bsel +: 8]; // [RULE_15]
          `CATM_G_EOC: nxt_rdata = done_ff[bsel +: 8];
          default: nxt_rdata = 8'h00;
        endcase
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign shadow_wr_o = shadow_wr_ff;
  assign shadow_addr_o = shadow_addr_ff;
  assign shadow_data_o = shadow_data_ff;

endmodule
`default_nettype wire

// [core/catm_life_acc.v]
/*
  One lifetime charge counter: 16 whole counts above a fraction remainder.
  Assumes inc_i is a one-cycle pulse with an unsigned sample magnitude.
*/
`timescale 1ns/10ps
`default_nettype none
`include "catm_defs.vh"

module catm_life_acc (
  input wire clk_i,
  input wire reset_n_i,
  input wire inc_i,
  input wire [15:0] mag_i,
  input wire wr_lo_i,
  input wire wr_hi_i,
  input wire [7:0] wdata_i,
  output wire [15:0] count_o,
  output reg bumped_o
);

  localparam W = 16 + `CATM_LIFE_FRAC;

  reg [W-1:0] acc_ff;
  reg [W-1:0] nxt_acc;
  reg [W-1:0] sum;

  always @* begin
    sum = acc_ff + {{(W-16){1'b0}}, mag_i}; // [RULE_19] [RULE_20]
    nxt_acc = acc_ff;
    if (inc_i) begin
      nxt_acc = sum;
    end
    if (wr_lo_i) begin
      nxt_acc[W-9:W-16] = wdata_i;
    end
    if (wr_hi_i) begin
      nxt_acc[W-1:W-8] = wdata_i;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      acc_ff <= {W{1'b0}};
      bumped_o <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      bumped_o <= inc_i && (sum[W-1:W-16] != acc_ff[W-1:W-16]);
    end
  end

  assign count_o = acc_ff[W-1:W-16]; // [RULE_08]

endmodule
`default_nettype wire

// [core/catm_sync2.v]
/*
  Two flip-flop synchroniser for one level.
  Assumes the input may change at any time relative to clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
`include "catm_defs.vh"

module catm_sync2 (
  input wire clk_i,
  input wire reset_n_i,
  input wire d_i,
  output wire q_o
);

  reg meta_ff;
  reg sync_ff;

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_ff <= `CATM_DQ_IDLE;
      sync_ff <= `CATM_DQ_IDLE;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule
`default_nettype wire

// [tb/catm_core_assertions.sv]
/*
  Checker on the core's ports.
  Assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module catm_core_assertions #(
  parameter [26:0] SEC_CYC = 27'd10,
  parameter [27:0] DISC_CYC = 28'd20
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire [5:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire recall_bit8_i,
  input wire sample_valid_i,
  input wire [15:0] sample_i,
  input wire dq_i,
  input wire sleep_o,
  input wire page7_owned_o,
  input wire shadow_wr_o,
  input wire [5:0] shadow_addr_o,
  input wire [15:0] shadow_data_o
);
  logic [2:0] st_ff;
  logic sign_ff;
  logic [27:0] low_ff;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_ff <= 3'h7;
      sign_ff <= 1'b0;
      low_ff <= 28'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == 6'h00) begin
        st_ff <= reg_wdata_i[2:0];
      end
      if (sample_valid_i) begin
        sign_ff <= sample_i[15];
      end
      low_ff <= dq_i ? 28'h0 : low_ff + 28'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_owned_bits: assert property (
    page7_owned_o == (st_ff[0] & st_ff[1])) else $error("owned flag wrong");
  a_shadow_gate: assert property (
    shadow_wr_o |-> st_ff == 3'h7 &&
    ($past(sample_valid_i) || $past(sample_valid_i, 2)))
    else $error("shadow without cause");
  a_shadow_single: assert property (
    shadow_wr_o |=> !shadow_wr_o) else $error("shadow pulse too long");
  a_shadow_addr: assert property (
    shadow_wr_o |-> shadow_addr_o == (sign_ff ? 6'h3e : 6'h3c))
    else $error("shadow address wrong");
  a_sleep_late: assert property (
    $rose(sleep_o) |-> low_ff >= DISC_CYC) else $error("sleep too early");
  a_sleep_quiet: assert property (
    sleep_o && $past(sleep_o) && $past(sleep_o, 2) |-> !shadow_wr_o)
    else $error("shadow while asleep");
  a_thresh_low: assert property (
    $past(reg_addr_i) == 6'h07 && $past(reset_n_i) |->
    reg_rdata_o[5:0] == 6'h00) else $error("threshold low bits set");
  a_unowned_read: assert property (
    $past(reg_addr_i[5:2]) == 4'hf && $past(!page7_owned_o) &&
    $past(reset_n_i) |-> reg_rdata_o == 8'h00)
    else $error("free page shows totals");
endmodule
bind catm_core catm_core_assertions #(
  .SEC_CYC(SEC_CYC), .DISC_CYC(DISC_CYC)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .recall_bit8_i(recall_bit8_i),
  .sample_valid_i(sample_valid_i), .sample_i(sample_i), .dq_i(dq_i),
  .sleep_o(sleep_o), .page7_owned_o(page7_owned_o),
  .shadow_wr_o(shadow_wr_o), .shadow_addr_o(shadow_addr_o),
  .shadow_data_o(shadow_data_o));
`default_nettype wire

// [tb/catm_host.sv]
/*
  Host bus master model: byte writes and reads, recall pulse, data line.
  Assumes the core's byte register port and a free-running clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module catm_host (
  input wire logic clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [5:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic recall_bit8_o,
  output logic dq_o
);
  initial begin
    reg_addr_o = 6'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    recall_bit8_o = 1'b0;
    dq_o = 1'b1;
  end
  // Page 7 is written only where a scenario asks for it.
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask
  task rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    repeat (2) @(negedge clk_i);
    d = reg_rdata_i;
  endtask
  task recall();
    @(negedge clk_i);
    recall_bit8_o = 1'b1;
    @(negedge clk_i);
    recall_bit8_o = 1'b0;
  endtask
  task line(input logic v);
    @(negedge clk_i);
    dq_o = v;
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
/*
  Self-checking bench for the charge and time core.
  Assumes the core with short second and disconnect counts.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic sv = 1'b0;
  logic [15:0] smp = 16'h0000;
  logic [5:0] ra;
  logic rw;
  logic [7:0] rwd;
  logic [7:0] rdat;
  logic rcl;
  logic dq;
  logic sleep;
  logic own;
  logic swr;
  logic [5:0] sh_a = 6'h00;
  logic [5:0] saddr;
  logic [15:0] sh_d = 16'h0000;
  logic [15:0] sdata;
  int sh_n = 0;
  int cyc = 0;
  int fail_count = 0;
  int total_checks = 0;
  always #4 clk_i = ~clk_i;
  catm_host host (.clk_i(clk_i), .reg_rdata_i(rdat), .reg_addr_o(ra),
    .reg_wr_o(rw), .reg_wdata_o(rwd), .recall_bit8_o(rcl), .dq_o(dq));
  catm_core #(.SEC_CYC(27'd10), .DISC_CYC(28'd20)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(ra),
    .reg_wr_i(rw), .reg_wdata_i(rwd), .reg_rdata_o(rdat),
    .recall_bit8_i(rcl), .sample_valid_i(sv), .sample_i(smp),
    .dq_i(dq), .sleep_o(sleep), .page7_owned_o(own),
    .shadow_wr_o(swr), .shadow_addr_o(saddr), .shadow_data_o(sdata));
  task tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (swr) begin
      sh_n++;
      sh_a = saddr;
      sh_d = sdata;
    end
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task rdc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    check({8'h00, d}, {8'h00, e});
  endtask
  task do_reset();
    @(negedge clk_i);
    reset_n_i = 1'b0;
    repeat (16) @(negedge clk_i);
    reset_n_i = 1'b1;
    sh_n = 0;
  endtask
  task burst(input int n, input logic [15:0] v);
    repeat (n) begin
      @(negedge clk_i);
      sv = 1'b1;
      smp = v;
      @(negedge clk_i);
      sv = 1'b0;
      smp = ~v;
      @(negedge clk_i);
    end
  endtask
  task set_sec();
    host.wr(6'h0b, 8'h12);
    host.wr(6'h0a, 8'h34);
    host.wr(6'h09, 8'h56);
    host.wr(6'h08, 8'h00);
  endtask
  task t_thresh();
    logic [15:0] th;
    for (int k = 0; k < 4; k++) begin
      th = (k == 0) ? 16'h0000 : 16'h0001 << k;
      do_reset();
      rdc(6'h00, 8'h07);
      host.wr(6'h07, {k[1:0], 6'h3f});
      rdc(6'h07, {k[1:0], 6'h00});
      set_sec();
      burst(1, th);
      burst(1, -th);
      rdc(6'h17, 8'h00);
      burst(1, th + 16'h0001);
      burst(1, -th - 16'h0001);
      rdc(6'h17, 8'h12);
      rdc(6'h15, 8'h56);
    end
    $display("threshold test done");
  endtask
  task t_time();
    do_reset();
    host.recall();
    host.wr(6'h0b, 8'hff);
    host.wr(6'h0a, 8'hff);
    host.wr(6'h09, 8'hff);
    host.wr(6'h08, 8'hf0);
    rdc(6'h0b, 8'h00);
    host.recall();
    rdc(6'h0b, 8'hff);
    repeat (170) @(negedge clk_i);
    host.recall();
    rdc(6'h0b, 8'h00);
    rdc(6'h09, 8'h00);
    $display("time test done");
  endtask
  task t_life();
    do_reset();
    burst(256, 16'h7fff);
    rdc(6'h3c, 8'h00);
    burst(1, 16'h7fff);
    rdc(6'h3c, 8'h01);
    rdc(6'h0c, 8'h20);
    check({10'h000, sh_a}, 16'h003c);
    check(sh_d, 16'h0001);
    burst(257, 16'h8001);
    rdc(6'h3e, 8'h01);
    rdc(6'h3c, 8'h01);
    rdc(6'h0c, 8'h00);
    check({10'h000, sh_a}, 16'h003e);
    host.wr(6'h3c, 8'hff);
    host.wr(6'h3d, 8'hff);
    burst(257, 16'h7fff);
    rdc(6'h3d, 8'h00);
    host.wr(6'h00, 8'h03);
    burst(257, 16'h8001);
    rdc(6'h3e, 8'h02);
    check(sh_n[15:0], 16'h0003);
    host.wr(6'h00, 8'h01);
    check({15'h0000, own}, 16'h0000);
    burst(257, 16'h8001);
    host.wr(6'h3e, 8'h55);
    rdc(6'h3e, 8'h00);
    host.wr(6'h00, 8'h03);
    rdc(6'h3e, 8'h02);
    host.wr(6'h00, 8'h06);
    check({15'h0000, own}, 16'h0000);
    burst(257, 16'h7fff);
    host.wr(6'h00, 8'h03);
    rdc(6'h0c, 8'h00);
    rdc(6'h3c, 8'h00);
    check(sh_n[15:0], 16'h0003);
    $display("lifetime test done");
  endtask
  task t_disc();
    int n;
    do_reset();
    set_sec();
    host.line(1'b0);
    n = 0;
    while (sleep !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    check({15'h0000, n >= 20 && n < 30}, 16'h0001);
    burst(257, 16'h7fff);
    check(sh_n[15:0], 16'h0000);
    host.line(1'b1);
    repeat (6) @(negedge clk_i);
    check({15'h0000, sleep}, 16'h0000);
    rdc(6'h3c, 8'h00);
    rdc(6'h13, 8'h12);
    rdc(6'h11, 8'h56);
    $display("disconnect test done");
  endtask
  initial begin
    do_reset();
    t_thresh();
    t_time();
    t_life();
    t_disc();
    tally_and_finish();
  end
endmodule
`default_nettype wire
